/* File: pkg/ctdv_pkg.sv */
// constants shared by the constants table debug view
package ctdv_pkg;

	localparam int          CTDV_ADDR_W    = 8;
	localparam int          CTDV_DATA_W    = 32;
	localparam int          CTDV_ENTRIES   = 5;

	// byte offsets of the entry view registers
	localparam logic [7:0]  CTDV_ENTRY9_OFF  = 8'hA4;
	localparam logic [7:0]  CTDV_ENTRY10_OFF = 8'hA8;
	localparam logic [7:0]  CTDV_ENTRY11_OFF = 8'hAC;
	localparam logic [7:0]  CTDV_ENTRY12_OFF = 8'hB0;
	localparam logic [7:0]  CTDV_ENTRY13_OFF = 8'hB4;

	// reset contents of the table entries
	localparam logic [31:0] CTDV_ENTRY9_RST  = 32'h4A100000;
	localparam logic [31:0] CTDV_ENTRY10_RST = 32'h48318000;
	localparam logic [31:0] CTDV_ENTRY11_RST = 32'h48022000;
	localparam logic [31:0] CTDV_ENTRY12_RST = 32'h48024000;
	localparam logic [31:0] CTDV_ENTRY13_RST = 32'h48310000;

	// answer to an unmapped read
	localparam logic [31:0] CTDV_UNMAPPED_DATA = 32'h00000000;

endpackage

/* File: logic/ctdv_view.sv */
// read-only debug window onto constants table entries 9 to 13
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module ctdv_view
	import ctdv_pkg::*;
(
	input  wire logic                              clock,
	input  wire logic                              resetn,
	input  wire logic                              realtime_core_enable,
	input  wire logic [ctdv_pkg::CTDV_ENTRIES*32-1:0] entry_live,
	input  wire logic [ctdv_pkg::CTDV_ENTRIES-1:0]  entry_load,
	input  wire logic [ctdv_pkg::CTDV_ADDR_W-1:0]  reg_addr,
	input  wire logic [ctdv_pkg::CTDV_DATA_W-1:0]  reg_wdata,
	input  wire logic                              reg_write,
	input  wire logic                              reg_read,
	output logic      [ctdv_pkg::CTDV_DATA_W-1:0]  reg_rdata,
	output logic                                   reg_rvalid
);
	import ctdv_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// offsets and reset values as tables, indexed by entry position
	localparam logic [CTDV_ENTRIES*8-1:0] offs = {
		CTDV_ENTRY13_OFF, CTDV_ENTRY12_OFF, CTDV_ENTRY11_OFF,
		CTDV_ENTRY10_OFF, CTDV_ENTRY9_OFF};
	localparam logic [CTDV_ENTRIES*32-1:0] rsts = {
		CTDV_ENTRY13_RST, CTDV_ENTRY12_RST, CTDV_ENTRY11_RST,
		CTDV_ENTRY10_RST, CTDV_ENTRY9_RST};

	logic [CTDV_DATA_W-1:0]  table_reg [CTDV_ENTRIES];
	logic [CTDV_ENTRIES-1:0] hit;
	logic [CTDV_DATA_W-1:0]  sel_data;
	logic                    any_hit;

	////////////////////////////////////////////////////////////////////////
	// one table entry per position; only the core side updates it
	for (genvar i = 0; i < CTDV_ENTRIES; i++) begin : g_entry
		// live input updates the entry whenever the core side loads it
		always_ff @(posedge clock) begin
			if (!resetn)
				table_reg[i] <= rsts[i*32 +: 32];
			else if (entry_load[i])
				table_reg[i] <= entry_live[i*32 +: 32];
		end
		// address decode; the write strobe is not part of any update
		assign hit[i] = (reg_addr == offs[i*8 +: 8]);
	end

	////////////////////////////////////////////////////////////////////////
	// read select; no enable gating so reads work with the core halted
	assign any_hit  = |hit;
	assign sel_data = hit[0] ? table_reg[0] :
	                  hit[1] ? table_reg[1] :
	                  hit[2] ? table_reg[2] :
	                  hit[3] ? table_reg[3] :
	                  hit[4] ? table_reg[4] : CTDV_UNMAPPED_DATA;

	// read data stand for one cycle only, zero otherwise
	always_ff @(posedge clock) begin
		if (!resetn) begin
			reg_rdata  <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata  <= reg_read ? sel_data : CTDV_UNMAPPED_DATA;
			reg_rvalid <= reg_read;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	logic [CTDV_DATA_W-1:0] t9_q;
	always_ff @(posedge clock) t9_q <= table_reg[0];

	sequence read_entry9_s;
		reg_read && reg_addr == CTDV_ENTRY9_OFF;
	endsequence

	entry9_read_a: assert property (@(posedge clock) disable iff (!resetn)
		read_entry9_s |=> reg_rdata == $past(table_reg[0]))
		else $error("entry 9 read data wrong");
	entry10_read_a: assert property (@(posedge clock) disable iff (!resetn)
		reg_read && reg_addr == CTDV_ENTRY10_OFF |=>
			reg_rdata == $past(table_reg[1]))
		else $error("entry 10 read data wrong");
	entry11_read_a: assert property (@(posedge clock) disable iff (!resetn)
		reg_read && reg_addr == CTDV_ENTRY11_OFF |=>
			reg_rdata == $past(table_reg[2]))
		else $error("entry 11 read data wrong");
	entry12_read_a: assert property (@(posedge clock) disable iff (!resetn)
		reg_read && reg_addr == CTDV_ENTRY12_OFF |=>
			reg_rdata == $past(table_reg[3]))
		else $error("entry 12 read data wrong");
	entry13_reset_a: assert property (@(posedge clock)
		!resetn |=> table_reg[4] == CTDV_ENTRY13_RST)
		else $error("entry 13 reset value wrong");
	halted_read_a: assert property (@(posedge clock) disable iff (!resetn)
		reg_read && !realtime_core_enable |=> reg_rvalid)
		else $error("read lost while core disabled");
	// without a read the answer must fall back to zero in the next cycle
	read_pulse_a: assert property (@(posedge clock) disable iff (!resetn)
		!reg_read |=> !reg_rvalid && reg_rdata == CTDV_UNMAPPED_DATA)
		else $error("read data held too long");
	live_value_a: assert property (@(posedge clock) disable iff (!resetn)
		entry_load[0] ##1 read_entry9_s |=>
			reg_rdata == $past(entry_live[31:0], 2))
		else $error("entry 9 not live");
	write_ignored_a: assert property (@(posedge clock) disable iff (!resetn)
		reg_write && !entry_load[0] |=> table_reg[0] == t9_q)
		else $error("write altered entry 9");

endmodule

/* File: test/ctdv_agent.sv */
// debug agent model issuing one-cycle register strobes
`timescale 1ns/1ps
module ctdv_agent (
	input  wire logic        clock,
	input  wire logic [31:0] rdata,
	input  wire logic        rvalid,
	output logic      [7:0]  addr,
	output logic      [31:0] wdata,
	output logic             write_stb,
	output logic             read_stb
);
	initial {addr, wdata, write_stb, read_stb} = '0;
	// all ones written, so a leak into the table cannot hide
	task automatic wr_reg(input logic [7:0] a);
		@(posedge clock);
		{addr, wdata, write_stb} <= {a, 32'hFFFFFFFF, 1'b1};
		@(posedge clock);
		{addr, wdata, write_stb} <= {~a, 32'h00000000, 1'b0};
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [32:0] d);
		@(posedge clock);
		{addr, read_stb} <= {a, 1'b1};
		@(posedge clock);
		{addr, read_stb} <= {~a, 1'b0};
		@(negedge clock);
		d = {rvalid, rdata};
	endtask
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the constants table debug view
`timescale 1ns/1ps
module tb_top;
	import ctdv_pkg::*;
	logic clock = 0, resetn = 0, core_en = 0, wr, rd, rvalid;
	logic [159:0] live = '0;
	logic [4:0] load = '0;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [32:0] got;
	int fails = 0, num_checks = 0, cycles = 0;
	logic [31:0] rst_val [5] = '{CTDV_ENTRY9_RST, CTDV_ENTRY10_RST,
		CTDV_ENTRY11_RST, CTDV_ENTRY12_RST, CTDV_ENTRY13_RST};
	always #2 clock = ~clock;
	ctdv_view dut (.clock(clock), .resetn(resetn),
		.realtime_core_enable(core_en), .entry_live(live),
		.entry_load(load), .reg_addr(addr), .reg_wdata(wdata),
		.reg_write(wr), .reg_read(rd), .reg_rdata(rdata),
		.reg_rvalid(rvalid));
	ctdv_agent agent (.clock(clock), .rdata(rdata), .rvalid(rvalid),
		.addr(addr), .wdata(wdata), .write_stb(wr), .read_stb(rd));
	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// each entry read at the current core enable, optionally after a write
	task automatic all_entries(input bit poke, input logic [31:0] ofs);
		for (int i = 0; i < 5; i++) begin
			if (poke) agent.wr_reg(CTDV_ENTRY9_OFF + 8'(4 * i));
			agent.rd_reg(CTDV_ENTRY9_OFF + 8'(4 * i), got);
			check(got, {1'b1, rst_val[i] + ofs});
		end
	endtask
	// core loads fresh values; reads must follow them, not reset copies
	task automatic live_entries();
		@(posedge clock);
		core_en <= 1'b1;
		for (int i = 0; i < 5; i++) live[i*32 +: 32] <= rst_val[i] + 32'h1;
		load <= 5'h1F;
		// read issued right behind the load, so the fresh value must show
		fork
			agent.rd_reg(CTDV_ENTRY9_OFF, got);
			begin
				@(posedge clock);
				load <= 5'h00;
			end
		join
		check(got, {1'b1, rst_val[0] + 32'h1});
		all_entries(1'b1, 32'h1);
		core_en <= 1'b0;
	endtask
	// unmapped word answers zero, and the answer lasts one cycle
	task automatic unmapped();
		agent.rd_reg(8'hB8, got);
		check(got, {1'b1, CTDV_UNMAPPED_DATA});
		@(negedge clock);
		check({rvalid, rdata}, 33'h000000000);
	endtask
	// cycle ceiling cuts a hang short
	always @(posedge clock) if (++cycles == 2000) begin
		fails++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		all_entries(1'b1, 32'h0);
		live_entries();
		unmapped();
		stop_test();
	end
endmodule
